// File: rtl/flash_cmd_pkg.sv
// Purpose: shared constants and types for the flash command controller and its user end
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: register offsets are word indexes on the Avalon-MM command port of the user end
package flash_cmd_pkg;
  localparam int ADDR_W = 32; // command address width, wide parts
  localparam int STAT_W = 8; // flash status byte width
  localparam int REQ_N = 6; // number of request lines

  // request line positions inside the request vector
  localparam int REQ_STATUS = 0;
  localparam int REQ_SECTOR = 1;
  localparam int REQ_DIE = 2;
  localparam int REQ_BULK = 3;
  localparam int REQ_ENTER = 4;
  localparam int REQ_EXIT = 5;

  // requests that are only taken while write-enable is high
  localparam logic [REQ_N-1:0] WREN_NEEDED = 6'h3E;

  // operation codes toward the flash engine and in the command register
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_STATUS = 3'h1,
    OP_SECTOR = 3'h2,
    OP_DIE = 3'h3,
    OP_BULK = 3'h4,
    OP_WIDE_ENTER = 3'h5,
    OP_WIDE_EXIT = 3'h6
  } op_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_EXEC = 2'h1,
    C_REJECT = 2'h2
  } ctrl_state_t;

  typedef enum logic [1:0] {
    U_IDLE = 2'h0,
    U_ARM = 2'h1,
    U_REQ = 2'h2,
    U_HOLD = 2'h3
  } user_state_t;

  localparam logic [1:0] REJECT_CYCLES = 2'h2; // erase-rejected pulse length
  localparam logic [3:0] ACCEPT_WAIT = 4'hF; // cycles the user end waits for an answer

  // avalon register word indexes
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_STATBYTE = 2'h3;

  // status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REJECT = 2;
  localparam int ST_IGNORED = 3;
  localparam int ST_WIDE = 4;
  localparam int CTRL_OP_MSB = 2; // op code field is [2:0]

  localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
  localparam logic [STAT_W-1:0] RST_STAT = 8'h00;
endpackage

// File: rtl/flash_cmd_if.sv
// Purpose: parallel command link between user logic and the flash command controller
// Assumes: all signals synchronous to sys_clk
// Notes: no clocking block; both ends drive from flip-flops
`timescale 1ns/10ps
`default_nettype none
interface flash_cmd_if;
  logic write_en; // write-enable gate for erase and mode requests
  logic status_read_req; // read flash status byte
  logic sector_erase_req; // erase sector holding addr
  logic die_erase_req; // erase die holding addr
  logic bulk_erase_req; // erase whole memory
  logic wide_addr_entry_req; // enter 4-byte addressing
  logic wide_addr_exit_req; // leave 4-byte addressing
  logic [flash_cmd_pkg::ADDR_W-1:0] addr; // target address
  logic busy; // operation in progress
  logic [flash_cmd_pkg::STAT_W-1:0] status_byte; // last status byte read
  logic erase_rejected; // two-cycle pulse, erase refused

  modport ctrl (
    input write_en, status_read_req, sector_erase_req, die_erase_req, bulk_erase_req,
    input wide_addr_entry_req, wide_addr_exit_req, addr,
    output busy, status_byte, erase_rejected
  );

  modport user (
    output write_en, status_read_req, sector_erase_req, die_erase_req, bulk_erase_req,
    output wide_addr_entry_req, wide_addr_exit_req, addr,
    input busy, status_byte, erase_rejected
  );
endinterface
`default_nettype wire

// File: rtl/flash_cmd_ctrl.sv
// Purpose: flash command controller for status read, erases and address-mode change
// Assumes: user inputs synchronous to sys_clk; a flash engine executes each op and
//   reports done plus protection of the addressed region
// Notes: one op at a time; requests are sampled only while idle
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - status byte valid when busy falls
// - user decodes protection from status byte
// - status byte only updated by status read
// - user reads status fresh before using it
// - sector erase sampled; addr selects sector
// - address first; busy during sector erase
// - sector erase without write-enable keeps busy low
// - protected erase cancelled, two-cycle reject pulse
// - held sector request re-runs after busy falls
// - bulk erase needs write-enable; busy until done
// - bulk erase without write-enable does nothing
// - held bulk request repeats after busy falls
// - die erase sampled with 32-bit addr
// - busy during die erase; needs write-enable
// - held die request repeats after busy falls
// - user raises write-enable then entry request
// - entry request ignored without write-enable
// - busy during wide-address entry
// - user enables wide mode on large parts
// - address buses are 32 bits wide
// - wide-address exit request input provided
// - exit needs write-enable; busy while exiting
// - status read sampled; busy; re-runs if held
module flash_cmd_ctrl (
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  flash_cmd_if.ctrl cmd, // user command link
  output logic op_start, // one-cycle pulse, start op on flash engine
  output var flash_cmd_pkg::op_t op_code, // op being executed
  output logic [flash_cmd_pkg::ADDR_W-1:0] op_addr, // address captured with the op
  input wire logic op_done, // flash engine finished the op
  input wire logic [flash_cmd_pkg::STAT_W-1:0] op_status, // status byte from engine
  input wire logic region_protected, // addressed sector or die is protected
  input wire logic any_protected, // some region of the memory is protected
  output logic wide_mode // flash is in 4-byte addressing
);

  flash_cmd_pkg::ctrl_state_t state_r;
  flash_cmd_pkg::ctrl_state_t state_nxt;
  flash_cmd_pkg::op_t code_r;
  flash_cmd_pkg::op_t code_nxt;
  flash_cmd_pkg::op_t pick;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr_r;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr_nxt;
  logic [flash_cmd_pkg::STAT_W-1:0] stat_r;
  logic [flash_cmd_pkg::STAT_W-1:0] stat_nxt;
  logic busy_r;
  logic busy_nxt;
  logic start_r;
  logic start_nxt;
  logic rej_r;
  logic rej_nxt;
  logic [1:0] rcnt_r;
  logic [1:0] rcnt_nxt;
  logic wide_r;
  logic wide_nxt;
  logic [flash_cmd_pkg::REQ_N-1:0] req_vec;
  logic [flash_cmd_pkg::REQ_N-1:0] acc_vec;
  logic is_region_erase;
  logic is_bulk;
  logic prot_hit;

  // gather request lines in a fixed order
  assign req_vec[flash_cmd_pkg::REQ_STATUS] = cmd.status_read_req;
  assign req_vec[flash_cmd_pkg::REQ_SECTOR] = cmd.sector_erase_req;
  assign req_vec[flash_cmd_pkg::REQ_DIE] = cmd.die_erase_req;
  assign req_vec[flash_cmd_pkg::REQ_BULK] = cmd.bulk_erase_req;
  assign req_vec[flash_cmd_pkg::REQ_ENTER] = cmd.wide_addr_entry_req;
  assign req_vec[flash_cmd_pkg::REQ_EXIT] = cmd.wide_addr_exit_req;

  // a request counts only with write-enable, except the status read
  genvar gi;
  generate
    for (gi = 0; gi < flash_cmd_pkg::REQ_N; gi++) begin : g_acc
      assign acc_vec[gi] = req_vec[gi] &
                           (cmd.write_en | ~flash_cmd_pkg::WREN_NEEDED[gi]);
    end
  endgenerate

  // fixed priority when several requests stand at once
  // status first so a status poll wins over erases standing in the same cycle;
  // the others stay high and are taken after this op ends
  assign pick = acc_vec[flash_cmd_pkg::REQ_STATUS] ? flash_cmd_pkg::OP_STATUS :
                acc_vec[flash_cmd_pkg::REQ_SECTOR] ? flash_cmd_pkg::OP_SECTOR :
                acc_vec[flash_cmd_pkg::REQ_DIE] ? flash_cmd_pkg::OP_DIE :
                acc_vec[flash_cmd_pkg::REQ_BULK] ? flash_cmd_pkg::OP_BULK :
                acc_vec[flash_cmd_pkg::REQ_ENTER] ? flash_cmd_pkg::OP_WIDE_ENTER :
                acc_vec[flash_cmd_pkg::REQ_EXIT] ? flash_cmd_pkg::OP_WIDE_EXIT :
                flash_cmd_pkg::OP_NONE;

  // protection check for the erase picked this cycle
  // protection inputs count only at accept; a later change
  // does not cancel an erase that the engine already runs
  // mode changes never hit protection and so are never rejected
  assign is_region_erase = (pick == flash_cmd_pkg::OP_SECTOR) ||
                           (pick == flash_cmd_pkg::OP_DIE);
  assign is_bulk = (pick == flash_cmd_pkg::OP_BULK);
  assign prot_hit = (is_region_erase & region_protected) | (is_bulk & any_protected);

  // next-state and datapath decisions
  always_comb begin
    state_nxt = state_r;
    code_nxt = code_r;
    addr_nxt = addr_r;
    stat_nxt = stat_r;
    busy_nxt = busy_r;
    start_nxt = 1'b0;
    rej_nxt = rej_r;
    rcnt_nxt = rcnt_r;
    wide_nxt = wide_r;
    case (state_r)
      flash_cmd_pkg::C_IDLE: begin
        // idle samples every cycle, so a request still held re-runs
        if (pick != flash_cmd_pkg::OP_NONE) begin
          if (prot_hit) begin
            // cancelled erase: busy stays low, reject flag pulses
            state_nxt = flash_cmd_pkg::C_REJECT;
            rej_nxt = 1'b1;
            rcnt_nxt = flash_cmd_pkg::REJECT_CYCLES - 2'h1;
          end else begin
            state_nxt = flash_cmd_pkg::C_EXEC;
            busy_nxt = 1'b1;
            start_nxt = 1'b1;
            code_nxt = pick;
            addr_nxt = cmd.addr;
          end
        end
      end
      flash_cmd_pkg::C_EXEC: begin
        // no timeout: an engine that never ends keeps busy high
        // and every request stays ignored until it does
        if (op_done) begin
          state_nxt = flash_cmd_pkg::C_IDLE;
          busy_nxt = 1'b0;
          // status byte lands on the same edge busy drops
          if (code_r == flash_cmd_pkg::OP_STATUS) begin
            stat_nxt = op_status;
          end
          if (code_r == flash_cmd_pkg::OP_WIDE_ENTER) begin
            wide_nxt = 1'b1;
          end
          if (code_r == flash_cmd_pkg::OP_WIDE_EXIT) begin
            wide_nxt = 1'b0;
          end
        end
      end
      flash_cmd_pkg::C_REJECT: begin
        // busy stays low; requests are ignored until the pulse ends
        if (rcnt_r == 2'h0) begin
          rej_nxt = 1'b0;
          state_nxt = flash_cmd_pkg::C_IDLE;
        end else begin
          rcnt_nxt = rcnt_r - 2'h1;
        end
      end
      default: begin
        // unused state code: back to idle with flags low
        state_nxt = flash_cmd_pkg::C_IDLE;
        busy_nxt = 1'b0;
        rej_nxt = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= flash_cmd_pkg::C_IDLE;
      code_r <= flash_cmd_pkg::OP_NONE;
      addr_r <= flash_cmd_pkg::RST_ADDR;
      stat_r <= flash_cmd_pkg::RST_STAT;
      busy_r <= 1'b0;
      start_r <= 1'b0;
      rej_r <= 1'b0;
      rcnt_r <= 2'h0;
      wide_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      addr_r <= addr_nxt;
      stat_r <= stat_nxt;
      busy_r <= busy_nxt;
      start_r <= start_nxt;
      rej_r <= rej_nxt;
      rcnt_r <= rcnt_nxt;
      wide_r <= wide_nxt;
    end
  end

  // outputs straight from the registers
  // status_byte keeps its value until the next status read ends
  assign cmd.busy = busy_r;
  assign cmd.status_byte = stat_r;
  assign cmd.erase_rejected = rej_r;
  assign op_start = start_r;
  assign op_code = code_r;
  assign op_addr = addr_r;
  assign wide_mode = wide_r;

endmodule
`default_nettype wire

// File: rtl/flash_cmd_user.sv
// Purpose: user-side end that turns Avalon-MM register orders into link requests
// Assumes: software writes ADDR, then CTRL with an op code, then polls STATUS
// Notes: requests are dropped as soon as busy or the reject pulse is seen
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_user (
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [1:0] avs_address, // word index
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, high until answer
  flash_cmd_if.user cmd // controller link
);

  flash_cmd_pkg::user_state_t st_r;
  flash_cmd_pkg::op_t op_r;
  flash_cmd_pkg::op_t wr_op;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr_r;
  logic [flash_cmd_pkg::REQ_N-1:0] req_r;
  logic [flash_cmd_pkg::REQ_N-1:0] req_sel;
  logic [3:0] wcnt_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic wait_r, wren_r, done_r, rej_r, ign_r, wide_r;
  logic wr_fire, ctrl_wr, addr_wr, stat_wr, u_idle, op_ok, need_wren;
  logic set_done, set_rej, set_ign;

  // bus decode: write takes effect where waitrequest is low
  assign wr_fire = avs_write & ~wait_r;
  assign u_idle = (st_r == flash_cmd_pkg::U_IDLE);
  assign wr_op = flash_cmd_pkg::op_t'(avs_writedata[flash_cmd_pkg::CTRL_OP_MSB:0]);
  assign op_ok = (wr_op != flash_cmd_pkg::OP_NONE) && (wr_op <= flash_cmd_pkg::OP_WIDE_EXIT);
  assign ctrl_wr = wr_fire && (avs_address == flash_cmd_pkg::REG_CTRL) && u_idle && op_ok;
  assign addr_wr = wr_fire && (avs_address == flash_cmd_pkg::REG_ADDR) && u_idle;
  assign stat_wr = wr_fire && (avs_address == flash_cmd_pkg::REG_STATUS);
  assign need_wren = (op_r != flash_cmd_pkg::OP_STATUS);

  // one request line per op code
  genvar gi;
  generate
    for (gi = 0; gi < flash_cmd_pkg::REQ_N; gi++) begin : g_sel
      assign req_sel[gi] = (op_r == flash_cmd_pkg::op_t'(3'(gi + 1)));
    end
  endgenerate

  // outcome events of the link sequence
  assign set_rej = (st_r == flash_cmd_pkg::U_REQ) && cmd.erase_rejected;
  assign set_ign = (st_r == flash_cmd_pkg::U_REQ) && !cmd.erase_rejected && !cmd.busy &&
                   (wcnt_r == 4'h0);
  assign set_done = (st_r == flash_cmd_pkg::U_HOLD) && !cmd.busy;

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == flash_cmd_pkg::REG_CTRL) begin
      rd_mux[flash_cmd_pkg::CTRL_OP_MSB:0] = op_r;
    end else if (avs_address == flash_cmd_pkg::REG_ADDR) begin
      rd_mux = addr_r;
    end else if (avs_address == flash_cmd_pkg::REG_STATUS) begin
      rd_mux[flash_cmd_pkg::ST_BUSY] = ~u_idle;
      rd_mux[flash_cmd_pkg::ST_DONE] = done_r;
      rd_mux[flash_cmd_pkg::ST_REJECT] = rej_r;
      rd_mux[flash_cmd_pkg::ST_IGNORED] = ign_r;
      rd_mux[flash_cmd_pkg::ST_WIDE] = wide_r;
    end else begin
      rd_mux[flash_cmd_pkg::STAT_W-1:0] = cmd.status_byte;
    end
  end

  // avalon slave: one wait cycle, then answer for one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
      if (avs_read & wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // sticky outcome flags: a set wins over a clear by write-one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      rej_r <= 1'b0;
      ign_r <= 1'b0;
    end else begin
      done_r <= set_done | (done_r & ~(stat_wr & avs_writedata[flash_cmd_pkg::ST_DONE]));
      rej_r <= set_rej | (rej_r & ~(stat_wr & avs_writedata[flash_cmd_pkg::ST_REJECT]));
      ign_r <= set_ign | (ign_r & ~(stat_wr & avs_writedata[flash_cmd_pkg::ST_IGNORED]));
    end
  end

  // link sequencer: address, then write-enable, then request, drop on answer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= flash_cmd_pkg::U_IDLE;
      op_r <= flash_cmd_pkg::OP_NONE;
      addr_r <= flash_cmd_pkg::RST_ADDR;
      req_r <= '0;
      wren_r <= 1'b0;
      wcnt_r <= 4'h0;
      wide_r <= 1'b0;
    end else begin
      if (addr_wr) begin
        addr_r <= avs_writedata;
      end
      case (st_r)
        flash_cmd_pkg::U_IDLE: begin
          if (ctrl_wr) begin
            op_r <= wr_op;
            st_r <= flash_cmd_pkg::U_ARM;
          end
        end
        flash_cmd_pkg::U_ARM: begin
          wren_r <= need_wren;
          st_r <= flash_cmd_pkg::U_REQ;
          wcnt_r <= flash_cmd_pkg::ACCEPT_WAIT;
        end
        flash_cmd_pkg::U_REQ: begin
          req_r <= req_sel;
          if (cmd.erase_rejected || cmd.busy || wcnt_r == 4'h0) begin
            req_r <= '0;
            wren_r <= 1'b0;
            st_r <= cmd.busy ? flash_cmd_pkg::U_HOLD : flash_cmd_pkg::U_IDLE;
          end else begin
            wcnt_r <= wcnt_r - 4'h1;
          end
        end
        flash_cmd_pkg::U_HOLD: begin
          if (!cmd.busy) begin
            st_r <= flash_cmd_pkg::U_IDLE;
            if (op_r == flash_cmd_pkg::OP_WIDE_ENTER) begin
              wide_r <= 1'b1;
            end
            if (op_r == flash_cmd_pkg::OP_WIDE_EXIT) begin
              wide_r <= 1'b0;
            end
          end
        end
        default: st_r <= flash_cmd_pkg::U_IDLE;
      endcase
    end
  end

  // drive bus and link from registers
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign cmd.write_en = wren_r;
  assign cmd.addr = addr_r;
  assign cmd.status_read_req = req_r[flash_cmd_pkg::REQ_STATUS];
  assign cmd.sector_erase_req = req_r[flash_cmd_pkg::REQ_SECTOR];
  assign cmd.die_erase_req = req_r[flash_cmd_pkg::REQ_DIE];
  assign cmd.bulk_erase_req = req_r[flash_cmd_pkg::REQ_BULK];
  assign cmd.wide_addr_entry_req = req_r[flash_cmd_pkg::REQ_ENTER];
  assign cmd.wide_addr_exit_req = req_r[flash_cmd_pkg::REQ_EXIT];

endmodule
`default_nettype wire

// File: testbench/flash_cmd_asserts.sv
// Purpose: concurrent checks on the command link between user end and controller
// Assumes: link signals sampled on sys_clk; sys_rst synchronous, active high
// Notes: the controller is idle whenever busy and the reject pulse are both low
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_asserts (
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic write_en, // write-enable gate
  input wire logic status_read_req, // status read request
  input wire logic sector_erase_req, // sector erase request
  input wire logic die_erase_req, // die erase request
  input wire logic bulk_erase_req, // bulk erase request
  input wire logic wide_addr_entry_req, // wide mode entry request
  input wire logic wide_addr_exit_req, // wide mode exit request
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr, // target address
  input wire logic busy, // operation in progress
  input wire logic [flash_cmd_pkg::STAT_W-1:0] status_byte, // last status byte
  input wire logic erase_rejected // reject pulse
);
  wire any_wreq; // requests gated by write-enable
  wire any_erase; // erase requests only
  assign any_erase = sector_erase_req | die_erase_req | bulk_erase_req;
  assign any_wreq = any_erase | wide_addr_entry_req | wide_addr_exit_req;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // status read is taken from idle with no gate
  property p_status_take;
    !busy && !erase_rejected && status_read_req |=> busy;
  endproperty
  a_status_take: assert property (p_status_take) else $error("status read not taken");
  // no gate and no status read: nothing starts
  property p_gate_low;
    !busy && !erase_rejected && !status_read_req && !write_en |=> !busy && !erase_rejected;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("ungated request acted on");
  property p_busy_cause;
    $rose(busy) |-> $past(status_read_req || (write_en && any_wreq));
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without request");
  property p_reject_len;
    $rose(erase_rejected) |-> ##1 erase_rejected ##1 !erase_rejected;
  endproperty
  a_reject_len: assert property (p_reject_len) else $error("reject pulse not two cycles");
  property p_reject_idle;
    erase_rejected |-> !busy;
  endproperty
  a_reject_idle: assert property (p_reject_idle) else $error("busy during reject");
  property p_reject_cause;
    $rose(erase_rejected) |-> $past(write_en && any_erase);
  endproperty
  a_reject_cause: assert property (p_reject_cause) else $error("reject without erase");
  // the status byte moves only in a cycle where busy falls
  property p_byte_hold;
    !$stable(status_byte) |-> $fell(busy);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("status byte moved on its own");
  property p_gate_first;
    $rose(any_wreq) |-> $past(write_en) && $stable(addr);
  endproperty
  a_gate_first: assert property (p_gate_first) else $error("request before gate or address");
  property p_drop;
    $fell(busy) |-> !status_read_req && !(write_en && any_wreq);
  endproperty
  a_drop: assert property (p_drop) else $error("request still held at busy fall");

  c_done: cover property ($fell(busy));
  c_reject: cover property ($rose(erase_rejected));
  c_status: cover property ($rose(busy) && $past(status_read_req));
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: self-checking bench for the user end and controller joined by the link
// Assumes: 20 MHz sys_clk; Avalon-MM master with waitrequest; engine modelled here
// Notes: a second controller is driven directly to misuse the link on purpose
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
  logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, op_addr, cap_addr;
  logic op_start, op_done, region_protected, any_protected, wide_mode, op_start2, b2;
  logic [7:0] op_status;
  flash_cmd_pkg::op_t op_code, cap_code;
  int miscompares, n_compared, cyc, eng_lat, cnt, n_start, n_rej, n_busy, n2;

  flash_cmd_if cmd_link ();
  flash_cmd_if cmd_link2 ();
  flash_cmd_ctrl flash_cmd_ctrl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd_link),
    .op_start(op_start), .op_code(op_code), .op_addr(op_addr), .op_done(op_done),
    .op_status(op_status), .region_protected(region_protected),
    .any_protected(any_protected), .wide_mode(wide_mode));
  flash_cmd_ctrl flash_cmd_ctrl_inst2 (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd_link2),
    .op_start(op_start2), .op_code(), .op_addr(), .op_done(1'b1), .op_status(8'h5A),
    .region_protected(1'b0), .any_protected(1'b0), .wide_mode());
  flash_cmd_user flash_cmd_user_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd(cmd_link));
  flash_cmd_asserts flash_cmd_asserts_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .write_en(cmd_link.write_en), .status_read_req(cmd_link.status_read_req),
    .sector_erase_req(cmd_link.sector_erase_req), .die_erase_req(cmd_link.die_erase_req),
    .bulk_erase_req(cmd_link.bulk_erase_req),
    .wide_addr_entry_req(cmd_link.wide_addr_entry_req),
    .wide_addr_exit_req(cmd_link.wide_addr_exit_req), .addr(cmd_link.addr),
    .busy(cmd_link.busy), .status_byte(cmd_link.status_byte),
    .erase_rejected(cmd_link.erase_rejected));

  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task final_report;
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // flash engine stand-in, event counters and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (op_start) cnt <= eng_lat;
    else if (cnt != 0) cnt <= cnt - 1;
    op_done <= (cnt == 1); // done some cycles after the start pulse
    if (op_start) begin
      cap_code = op_code;
      cap_addr = op_addr;
      n_start++;
    end
    if (cmd_link.busy) n_busy++;
    if (cmd_link.erase_rejected) n_rej++;
    if (op_start2) n2++;
    if (cmd_link2.busy) b2 = 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end

  // avalon write: hold until waitrequest is sampled low
  task automatic av_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin @(posedge sys_clk); end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // avalon read: data taken at the edge that ends the wait
  task automatic av_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin @(posedge sys_clk); end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // issue one op through the registers and wait for its outcome
  task automatic run_op(input logic [2:0] op, input logic [31:0] a, output logic [31:0] st);
    int n;
    n_start = 0;
    n_rej = 0;
    n_busy = 0;
    av_wr(flash_cmd_pkg::REG_ADDR, a);
    av_wr(flash_cmd_pkg::REG_CTRL, {29'h0, op});
    n = 0;
    do begin av_rd(flash_cmd_pkg::REG_STATUS, st); n++; end while (st[3:1] === 3'h0 && n < 100);
    repeat (4) @(posedge sys_clk);
    av_wr(flash_cmd_pkg::REG_STATUS, 32'h0000_000E);
  endtask

  task t_status;
    logic [31:0] st;
    logic [31:0] rd;
    `CHK(cmd_link.busy, 1'b0)
    `CHK(cmd_link.status_byte, 8'h00)
    op_status <= 8'hA5;
    run_op(3'h1, 32'h0000_0000, st);
    `CHK(cmd_link.status_byte, 8'hA5)
    av_rd(flash_cmd_pkg::REG_STATBYTE, rd);
    `CHK(rd[7:0], 8'hA5)
    op_status <= 8'h3C;
    run_op(3'h2, 32'h0001_0000, st);
    `CHK(cmd_link.status_byte, 8'hA5)
    run_op(3'h1, 32'h0000_0000, st);
    `CHK(cmd_link.status_byte, 8'h3C)
  endtask

  task t_erases;
    logic [31:0] st;
    logic [31:0] a;
    for (int i = 2; i <= 4; i++) begin
      a = {28'hFEDC_BA9, i[3:0]};
      run_op(i[2:0], a, st);
      `CHK(cap_code, flash_cmd_pkg::op_t'(i))
      `CHK(cap_addr, a)
      `CHK(n_start, 1)
      `CHK(n_busy, eng_lat + 2)
      `CHK(st[flash_cmd_pkg::ST_DONE], 1'b1)
    end
  endtask

  task t_reject;
    logic [31:0] st;
    for (int i = 2; i <= 4; i++) begin
      region_protected <= (i != 4);
      any_protected <= (i == 4);
      run_op(i[2:0], 32'h0000_0100, st);
      `CHK(n_rej, 2)
      `CHK(n_start, 0)
      `CHK(n_busy, 0)
      `CHK(st[flash_cmd_pkg::ST_REJECT], 1'b1)
    end
    region_protected <= 1'b0;
    any_protected <= 1'b0;
  endtask

  task t_wide;
    logic [31:0] st;
    run_op(3'h5, 32'h0000_0000, st);
    `CHK(cap_code, flash_cmd_pkg::OP_WIDE_ENTER)
    `CHK(wide_mode, 1'b1)
    `CHK(st[flash_cmd_pkg::ST_WIDE], 1'b1)
    run_op(3'h6, 32'h0000_0000, st);
    `CHK(cap_code, flash_cmd_pkg::OP_WIDE_EXIT)
    `CHK(wide_mode, 1'b0)
    n_start = 0;
    av_wr(flash_cmd_pkg::REG_CTRL, 32'h0000_0007);
    av_wr(flash_cmd_pkg::REG_CTRL, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    `CHK(n_start, 0)
  endtask

  // misuse of the second link: held, ungated and repeated requests
  task t_held;
    @(posedge sys_clk);
    cmd_link2.addr <= 32'h0012_3400;
    @(posedge sys_clk);
    cmd_link2.write_en <= 1'b1;
    @(posedge sys_clk);
    n2 = 0;
    cmd_link2.sector_erase_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cmd_link2.sector_erase_req <= 1'b0;
    cmd_link2.write_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(n2 >= 2, 1'b1)
    n2 = 0;
    b2 = 1'b0;
    {cmd_link2.sector_erase_req, cmd_link2.die_erase_req, cmd_link2.bulk_erase_req,
      cmd_link2.wide_addr_entry_req, cmd_link2.wide_addr_exit_req} <= 5'h1F;
    repeat (8) @(posedge sys_clk);
    {cmd_link2.sector_erase_req, cmd_link2.die_erase_req, cmd_link2.bulk_erase_req,
      cmd_link2.wide_addr_entry_req, cmd_link2.wide_addr_exit_req} <= 5'h00;
    repeat (2) @(posedge sys_clk);
    `CHK(n2, 0)
    `CHK(b2, 1'b0)
    cmd_link2.status_read_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cmd_link2.status_read_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(n2 >= 2, 1'b1)
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {op_done, region_protected, any_protected, op_status} = '0;
    {miscompares, n_compared, cyc, cnt, n_start, n_rej, n_busy, n2, b2} = '0;
    eng_lat = 5;
    {cmd_link2.write_en, cmd_link2.status_read_req, cmd_link2.sector_erase_req} = '0;
    {cmd_link2.die_erase_req, cmd_link2.bulk_erase_req, cmd_link2.addr} = '0;
    {cmd_link2.wide_addr_entry_req, cmd_link2.wide_addr_exit_req} = '0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_status;
    t_erases;
    t_reject;
    t_wide;
    t_held;
    final_report;
  end
endmodule
`default_nettype wire
